// File: logic/vsca_consts.svh
/*
 * Constants of the vector saturated-add and all-lanes compare slice:
 * instruction field positions, opcodes, lane and data widths.
 * Assumes it is included by bare name from the slice's design files.
 */
`ifndef VSCA_CONSTS_SVH
`define VSCA_CONSTS_SVH

`define VSCA_DATA_W 64
`define VSCA_WORD_W 32
`define VSCA_IDX_W 5
`define VSCA_BYTE_W 8
`define VSCA_HALF_W 16

`define VSCA_PRIMARY_MSB 31
`define VSCA_PRIMARY_LSB 26
`define VSCA_DEST_MSB 25
`define VSCA_DEST_LSB 21
`define VSCA_SRC_A_MSB 20
`define VSCA_SRC_A_LSB 16
`define VSCA_SRC_B_MSB 15
`define VSCA_SRC_B_LSB 11
`define VSCA_MINOR_MSB 7
`define VSCA_MINOR_LSB 0

`define VSCA_PRIMARY_OP 6'h0A
`define VSCA_MINOR_ADDUS_B 8'h36
`define VSCA_MINOR_ADDUS_H 8'h37
`define VSCA_MINOR_EQ_B 8'h10
`define VSCA_MINOR_EQ_H 8'h11
`define VSCA_MINOR_GE_B 8'h12
`define VSCA_MINOR_GE_H 8'h13
`define VSCA_MINOR_GT_B 8'h14
`define VSCA_MINOR_GT_H 8'h15
`define VSCA_MINOR_LE_B 8'h16
`define VSCA_MINOR_LE_H 8'h17

`define VSCA_DATA_RESET 64'h0000_0000_0000_0000
`define VSCA_IDX_RESET 5'h00

`endif

// File: logic/vsca_pkg.sv
/*
 * Types shared by the vector saturated-add and all-lanes compare slice.
 * Assumes vsca_consts.svh is on the include path.
 */
`include "vsca_consts.svh"

package vsca_pkg;
    typedef logic [`VSCA_WORD_W-1:0] vsca_word_type;
    typedef logic [`VSCA_DATA_W-1:0] vsca_data_type;
    typedef logic [`VSCA_IDX_W-1:0] vsca_idx_type;

    typedef enum logic [3:0] {
        VSCA_OP_NONE     = 4'h0,
        VSCA_OP_ADDUS_B  = 4'h1,
        VSCA_OP_ADDUS_H  = 4'h2,
        VSCA_OP_EQ_B     = 4'h3,
        VSCA_OP_EQ_H     = 4'h4,
        VSCA_OP_GE_B     = 4'h5,
        VSCA_OP_GE_H     = 4'h6,
        VSCA_OP_GT_B     = 4'h7,
        VSCA_OP_GT_H     = 4'h8,
        VSCA_OP_LE_B     = 4'h9,
        VSCA_OP_LE_H     = 4'hA
    } vsca_op_type;
endpackage

// File: logic/vsca_lane_unit.sv
/*
 * Per-lane unsigned saturating adder and comparator for one lane width.
 * Assumes purely combinational use inside the slice; no clock.
 */
`timescale 1ns/1ps

module vsca_lane_unit #(
    parameter int DATA_W = 64,
    parameter int LANE_W = 8
) (
    input wire logic [DATA_W-1:0] a_i,
    input wire logic [DATA_W-1:0] b_i,
    output logic [DATA_W-1:0] sat_sum_o,
    output logic [DATA_W/LANE_W-1:0] eq_o,
    output logic [DATA_W/LANE_W-1:0] gt_o
);
    localparam int LANES = DATA_W / LANE_W;

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [LANE_W:0] sum;
            logic [LANE_W-1:0] a_lane;
            logic [LANE_W-1:0] b_lane;
            assign a_lane = a_i[g*LANE_W +: LANE_W];
            assign b_lane = b_i[g*LANE_W +: LANE_W];
            // carry out of the lane means the unsigned maximum was passed
            assign sum = {1'b0, a_lane} + {1'b0, b_lane};
            assign sat_sum_o[g*LANE_W +: LANE_W] = sum[LANE_W] ? {LANE_W{1'b1}} :
                sum[LANE_W-1:0];
            assign eq_o[g] = (a_lane == b_lane);
            assign gt_o[g] = (a_lane > b_lane);
        end
    endgenerate
endmodule

// File: logic/vsca_alu.sv
/*
 * 64-bit packed-vector slice: unsigned saturated add of byte and half-word
 * lanes and the all-lanes compare group. Assumes the register file reads
 * combinationally on the source indices and accepts one write per cycle.
 */
// What this block does
// - byte saturated add: eight 8-bit lanes, each sum clamped to 0xFF
// - half-word saturated add, minor opcode 0x37: four lanes clamped to 0xFFFF
// - fields from top: 6-bit primary 0xa, dest, src1, src2, 3 reserved, 8-bit minor
// - byte all-equal, minor 0x10: flag set only if all eight lanes match
// - half-word all-equal, minor 0x11: flag set only if all four lanes match
// - every compare writes its flag into all 64 destination bits
// - byte all-at-least, minor 0x12: every first lane >= second lane
// - half-word all-at-least: every first lane >= second lane
// - byte all-above, minor 0x14: every first lane > second lane
// - half-word all-above, minor 0x15: every first lane > second lane
// - byte all-at-most, minor 0x16: every first lane <= second lane
// - half-word all-at-most, minor 0x17: every first lane <= second lane
`timescale 1ns/1ps
`include "vsca_consts.svh"

module vsca_alu #(
    parameter int DATA_W = `VSCA_DATA_W
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic issue_valid_i,
    input wire vsca_pkg::vsca_word_type issue_word_i,
    input wire vsca_pkg::vsca_data_type first_source_reg_i,
    input wire vsca_pkg::vsca_data_type second_source_reg_i,
    output logic issue_accept_o,
    output vsca_pkg::vsca_idx_type first_source_idx_o,
    output vsca_pkg::vsca_idx_type second_source_idx_o,
    output logic gpr_we_o,
    output vsca_pkg::vsca_idx_type gpr_wr_idx_o,
    output vsca_pkg::vsca_data_type gpr_wr_data_o,
    output logic cmp_flag_we_o,
    output logic cmp_flag_o
);
    import vsca_pkg::*;

    localparam int BYTE_LANES = DATA_W / `VSCA_BYTE_W;
    localparam int HALF_LANES = DATA_W / `VSCA_HALF_W;

    // instruction decode, shared by the datapath and the checks below
    function automatic vsca_op_type decode_op(input vsca_word_type word);
        vsca_op_type op;
        op = VSCA_OP_NONE;
        if (word[`VSCA_PRIMARY_MSB:`VSCA_PRIMARY_LSB] == `VSCA_PRIMARY_OP) begin
            case (word[`VSCA_MINOR_MSB:`VSCA_MINOR_LSB])
                `VSCA_MINOR_ADDUS_B: op = VSCA_OP_ADDUS_B;
                `VSCA_MINOR_ADDUS_H: op = VSCA_OP_ADDUS_H;
                `VSCA_MINOR_EQ_B: op = VSCA_OP_EQ_B;
                `VSCA_MINOR_EQ_H: op = VSCA_OP_EQ_H;
                `VSCA_MINOR_GE_B: op = VSCA_OP_GE_B;
                `VSCA_MINOR_GE_H: op = VSCA_OP_GE_H;
                `VSCA_MINOR_GT_B: op = VSCA_OP_GT_B;
                `VSCA_MINOR_GT_H: op = VSCA_OP_GT_H;
                `VSCA_MINOR_LE_B: op = VSCA_OP_LE_B;
                `VSCA_MINOR_LE_H: op = VSCA_OP_LE_H;
                default: op = VSCA_OP_NONE;
            endcase
        end
        return op;
    endfunction

    function automatic logic is_compare(input vsca_op_type op);
        return (op != VSCA_OP_NONE) && (op != VSCA_OP_ADDUS_B) &&
            (op != VSCA_OP_ADDUS_H);
    endfunction

    vsca_op_type cur_op;
    logic take;
    logic [DATA_W-1:0] byte_sum;
    logic [DATA_W-1:0] half_sum;
    logic [BYTE_LANES-1:0] byte_eq;
    logic [BYTE_LANES-1:0] byte_gt;
    logic [HALF_LANES-1:0] half_eq;
    logic [HALF_LANES-1:0] half_gt;
    logic flag_calc;

    logic gpr_we_ff;
    logic nxt_gpr_we;
    vsca_idx_type gpr_wr_idx_ff;
    vsca_idx_type nxt_gpr_wr_idx;
    vsca_data_type gpr_wr_data_ff;
    vsca_data_type nxt_gpr_wr_data;
    logic cmp_flag_we_ff;
    logic nxt_cmp_flag_we;
    logic cmp_flag_ff;
    logic nxt_cmp_flag;

    assign cur_op = issue_valid_i ? decode_op(issue_word_i) : VSCA_OP_NONE;
    assign take = (cur_op != VSCA_OP_NONE);
    // reserved bits 10:8 are not looked at; any encoding there is accepted
    assign issue_accept_o = take;
    assign first_source_idx_o = issue_word_i[`VSCA_SRC_A_MSB:`VSCA_SRC_A_LSB];
    assign second_source_idx_o = issue_word_i[`VSCA_SRC_B_MSB:`VSCA_SRC_B_LSB];

    vsca_lane_unit #(
        .DATA_W(DATA_W),
        .LANE_W(`VSCA_BYTE_W)
    ) u_byte_lanes (
        .a_i(first_source_reg_i),
        .b_i(second_source_reg_i),
        .sat_sum_o(byte_sum),
        .eq_o(byte_eq),
        .gt_o(byte_gt)
    );

    vsca_lane_unit #(
        .DATA_W(DATA_W),
        .LANE_W(`VSCA_HALF_W)
    ) u_half_lanes (
        .a_i(first_source_reg_i),
        .b_i(second_source_reg_i),
        .sat_sum_o(half_sum),
        .eq_o(half_eq),
        .gt_o(half_gt)
    );

    // at-least is the lane-wise or of equal and above; at-most is not above
    always_comb begin
        case (cur_op)
            VSCA_OP_EQ_B: flag_calc = &byte_eq;
            VSCA_OP_EQ_H: flag_calc = &half_eq;
            VSCA_OP_GE_B: flag_calc = &(byte_eq | byte_gt);
            VSCA_OP_GE_H: flag_calc = &(half_eq | half_gt);
            VSCA_OP_GT_B: flag_calc = &byte_gt;
            VSCA_OP_GT_H: flag_calc = &half_gt;
            VSCA_OP_LE_B: flag_calc = &(~byte_gt);
            VSCA_OP_LE_H: flag_calc = &(~half_gt);
            default: flag_calc = 1'b0;
        endcase
    end

    // result stage: one cycle from issue to register-file write
    always_comb begin
        nxt_gpr_we = take;
        nxt_gpr_wr_idx = gpr_wr_idx_ff;
        nxt_gpr_wr_data = gpr_wr_data_ff;
        nxt_cmp_flag_we = 1'b0;
        // flag holds between compares; adds leave it alone
        nxt_cmp_flag = cmp_flag_ff;
        if (take) begin
            nxt_gpr_wr_idx = issue_word_i[`VSCA_DEST_MSB:`VSCA_DEST_LSB];
        end
        case (cur_op)
            VSCA_OP_ADDUS_B: nxt_gpr_wr_data = byte_sum;
            VSCA_OP_ADDUS_H: nxt_gpr_wr_data = half_sum;
            default: begin
                if (is_compare(cur_op)) begin
                    nxt_cmp_flag_we = 1'b1;
                    nxt_cmp_flag = flag_calc;
                    nxt_gpr_wr_data = {DATA_W{flag_calc}};
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gpr_we_ff <= 1'b0;
            gpr_wr_idx_ff <= `VSCA_IDX_RESET;
            gpr_wr_data_ff <= `VSCA_DATA_RESET;
            cmp_flag_we_ff <= 1'b0;
            cmp_flag_ff <= 1'b0;
        end else begin
            gpr_we_ff <= nxt_gpr_we;
            gpr_wr_idx_ff <= nxt_gpr_wr_idx;
            gpr_wr_data_ff <= nxt_gpr_wr_data;
            cmp_flag_we_ff <= nxt_cmp_flag_we;
            cmp_flag_ff <= nxt_cmp_flag;
        end
    end

    // no exception or overflow port exists; saturation is silent
    assign gpr_we_o = gpr_we_ff;
    assign gpr_wr_idx_o = gpr_wr_idx_ff;
    assign gpr_wr_data_o = gpr_wr_data_ff;
    assign cmp_flag_we_o = cmp_flag_we_ff;
    assign cmp_flag_o = cmp_flag_ff;

    // independent lane sums for the checks, top byte and bottom half-word
    logic [8:0] chk_byte_sum;
    logic [16:0] chk_half_sum;
    assign chk_byte_sum = {1'b0, first_source_reg_i[63:56]} +
        {1'b0, second_source_reg_i[63:56]};
    assign chk_half_sum = {1'b0, first_source_reg_i[15:0]} +
        {1'b0, second_source_reg_i[15:0]};

    sequence s_issue(vsca_op_type op);
        issue_valid_i && (decode_op(issue_word_i) == op);
    endsequence

    sequence s_flag_written(logic val);
        cmp_flag_we_o && (cmp_flag_o == val);
    endsequence

    property p_sat_byte;
        @(posedge mclk_i) disable iff (!rst_n_i)
        s_issue(VSCA_OP_ADDUS_B) |=> gpr_we_o &&
            gpr_wr_data_o[63:56] == ($past(chk_byte_sum[8]) ? 8'hFF :
            $past(chk_byte_sum[7:0]));
    endproperty
    a_sat_byte: assert property (p_sat_byte)
        else $error("byte lane add not clamped to unsigned maximum");

    property p_sat_half;
        @(posedge mclk_i) disable iff (!rst_n_i)
        s_issue(VSCA_OP_ADDUS_H) |=> gpr_we_o && !cmp_flag_we_o &&
            gpr_wr_data_o[15:0] == ($past(chk_half_sum[16]) ? 16'hFFFF :
            $past(chk_half_sum[15:0]));
    endproperty
    a_sat_half: assert property (p_sat_half)
        else $error("half-word lane add not clamped to unsigned maximum");

    property p_fields;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (issue_valid_i && issue_accept_o) |->
            first_source_idx_o == issue_word_i[20:16] &&
            second_source_idx_o == issue_word_i[15:11] &&
            issue_word_i[31:26] == 6'h0A
            ##1 gpr_we_o && gpr_wr_idx_o == $past(issue_word_i[25:21]);
    endproperty
    a_fields: assert property (p_fields)
        else $error("instruction fields taken from wrong bit positions");

    property p_eq_byte;
        @(posedge mclk_i) disable iff (!rst_n_i)
        s_issue(VSCA_OP_EQ_B) |=>
            s_flag_written($past(first_source_reg_i == second_source_reg_i));
    endproperty
    a_eq_byte: assert property (p_eq_byte)
        else $error("byte all-equal flag wrong");

    property p_eq_half;
        @(posedge mclk_i) disable iff (!rst_n_i)
        s_issue(VSCA_OP_EQ_H) ##0
            (first_source_reg_i[63:48] != second_source_reg_i[63:48])
            |=> s_flag_written(1'b0);
    endproperty
    a_eq_half: assert property (p_eq_half)
        else $error("half-word all-equal flag set with a differing lane");

    property p_replicate;
        @(posedge mclk_i) disable iff (!rst_n_i)
        cmp_flag_we_o |-> gpr_we_o &&
            gpr_wr_data_o == {64{cmp_flag_o}};
    endproperty
    a_replicate: assert property (p_replicate)
        else $error("compare flag not replicated into destination");

    property p_ge_byte;
        @(posedge mclk_i) disable iff (!rst_n_i)
        s_issue(VSCA_OP_GE_B) ##0
            (first_source_reg_i[7:0] < second_source_reg_i[7:0])
            |=> s_flag_written(1'b0);
    endproperty
    a_ge_byte: assert property (p_ge_byte)
        else $error("byte all-at-least flag set with a smaller lane");

    property p_ge_half;
        @(posedge mclk_i) disable iff (!rst_n_i)
        s_issue(VSCA_OP_GE_H) ##0
            (first_source_reg_i == second_source_reg_i)
            |=> s_flag_written(1'b1);
    endproperty
    a_ge_half: assert property (p_ge_half)
        else $error("half-word all-at-least flag clear on equal sources");

    property p_gt_byte;
        @(posedge mclk_i) disable iff (!rst_n_i)
        s_issue(VSCA_OP_GT_B) ##0
            (first_source_reg_i[39:32] == second_source_reg_i[39:32])
            |=> s_flag_written(1'b0);
    endproperty
    a_gt_byte: assert property (p_gt_byte)
        else $error("byte all-above flag set with an equal lane");

    property p_gt_half;
        @(posedge mclk_i) disable iff (!rst_n_i)
        s_issue(VSCA_OP_GT_H) ##0
            (first_source_reg_i[31:16] <= second_source_reg_i[31:16])
            |=> s_flag_written(1'b0);
    endproperty
    a_gt_half: assert property (p_gt_half)
        else $error("half-word all-above flag set with a lane not above");

    property p_le_byte;
        @(posedge mclk_i) disable iff (!rst_n_i)
        s_issue(VSCA_OP_LE_B) ##0
            (first_source_reg_i == second_source_reg_i)
            |=> s_flag_written(1'b1);
    endproperty
    a_le_byte: assert property (p_le_byte)
        else $error("byte all-at-most flag clear on equal sources");

    property p_le_half;
        @(posedge mclk_i) disable iff (!rst_n_i)
        s_issue(VSCA_OP_LE_H) ##0
            (first_source_reg_i[15:0] > second_source_reg_i[15:0])
            |=> s_flag_written(1'b0);
    endproperty
    a_le_half: assert property (p_le_half)
        else $error("half-word all-at-most flag set with a larger lane");

    property p_quiet;
        @(posedge mclk_i) disable iff (!rst_n_i)
        !issue_accept_o |=> !gpr_we_o && !cmp_flag_we_o && $stable(cmp_flag_o);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("state changed without an accepted instruction");

    property p_add_keeps_flag;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (s_issue(VSCA_OP_ADDUS_B) or s_issue(VSCA_OP_ADDUS_H))
            |=> !cmp_flag_we_o && $stable(cmp_flag_o);
    endproperty
    a_add_keeps_flag: assert property (p_add_keeps_flag)
        else $error("saturated add disturbed the compare flag");
endmodule

// File: verification/vsca_gpr_model.sv
/*
 * Behavioural general-purpose register file standing beside the slice.
 * Assumes one clock; reads are combinational on the slice's source indices,
 * and the bench preloads entries through a separate load port.
 */
`timescale 1ns/1ps

module vsca_gpr_model (
    input wire logic mclk_i,
    input wire logic load_we_i,
    input wire logic [4:0] load_idx_i,
    input wire logic [63:0] load_data_i,
    input wire logic [4:0] rd_a_idx_i,
    input wire logic [4:0] rd_b_idx_i,
    input wire logic we_i,
    input wire logic [4:0] wr_idx_i,
    input wire logic [63:0] wr_data_i,
    output logic [63:0] rd_a_o,
    output logic [63:0] rd_b_o
);
    logic [63:0] mem [32];

    assign rd_a_o = mem[rd_a_idx_i];
    assign rd_b_o = mem[rd_b_idx_i];

    // a preload wins over a slice write in the same cycle; the bench never overlaps them
    always @(posedge mclk_i) begin
        if (load_we_i) begin
            mem[load_idx_i] <= load_data_i;
        end else if (we_i) begin
            mem[wr_idx_i] <= wr_data_i;
        end
    end
endmodule

// File: verification/tb.sv
/*
 * Self-checking bench of the vector saturated-add and compare slice.
 * Assumes the register file model above; sources come from entries 0..23
 * and results land in 24..31, so reads never depend on pending writes.
 */
`timescale 1ns/1ps
`include "vsca_consts.svh"

module tb;
    import vsca_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic issue_valid_i = 1'b0;
    vsca_word_type issue_word_i = '0;
    logic load_we = 1'b0;
    logic [4:0] load_idx = 5'h00;
    logic [63:0] load_data = 64'h0;
    vsca_data_type src_a, src_b, wr_data;
    vsca_idx_type idx_a, idx_b, wr_idx;
    logic accept, we, flag_we, flag;
    logic [63:0] shadow [32];
    logic [70:0] exp_q [$];
    logic [70:0] mon_e;
    logic exp_flag = 1'b0;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [7:0] ops [10] = '{8'h36, 8'h37, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
                             8'h16, 8'h17};

    vsca_alu dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .issue_valid_i(issue_valid_i),
        .issue_word_i(issue_word_i), .first_source_reg_i(src_a), .second_source_reg_i(src_b),
        .issue_accept_o(accept), .first_source_idx_o(idx_a), .second_source_idx_o(idx_b),
        .gpr_we_o(we), .gpr_wr_idx_o(wr_idx), .gpr_wr_data_o(wr_data),
        .cmp_flag_we_o(flag_we), .cmp_flag_o(flag));

    vsca_gpr_model gpr (.mclk_i(mclk_i), .load_we_i(load_we), .load_idx_i(load_idx),
        .load_data_i(load_data), .rd_a_idx_i(idx_a), .rd_b_idx_i(idx_b), .we_i(we),
        .wr_idx_i(wr_idx), .wr_data_i(wr_data), .rd_a_o(src_a), .rd_b_o(src_b));

    always #2 mclk_i = ~mclk_i;

    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // independent lane model: returns {flag, data}
    function automatic logic [64:0] ref_op(input logic [7:0] mn, input logic [63:0] a,
                                           input logic [63:0] b);
        logic f;
        logic [63:0] d;
        logic [16:0] s;
        logic [15:0] x, y, mask;
        int w;
        f = 1'b1;
        d = 64'h0;
        w = mn[0] ? 16 : 8;
        mask = mn[0] ? 16'hFFFF : 16'h00FF;
        for (int i = 0; i < 64 / w; i++) begin
            x = 16'(a >> (i * w)) & mask;
            y = 16'(b >> (i * w)) & mask;
            s = x + y;
            if (s > 17'(mask)) begin
                s = 17'(mask);
            end
            d = d | (64'(s[15:0]) << (i * w));
            case (mn[7:1])
                7'h08: f = f & (x == y);
                7'h09: f = f & (x >= y);
                7'h0A: f = f & (x > y);
                7'h0B: f = f & (x <= y);
                default: f = f;
            endcase
        end
        if (mn[5:4] == 2'b01) begin
            d = {64{f}};
        end
        return {f, d};
    endfunction

    task automatic issue(input logic v, input logic [5:0] pri, input logic [4:0] d,
                         input logic [4:0] s1, input logic [4:0] s2, input logic [7:0] mn);
        logic acc;
        logic known;
        known = (mn[7:3] == 5'h02) || (mn == 8'h36) || (mn == 8'h37);
        acc = v && (pri == `VSCA_PRIMARY_OP) && known;
        @(posedge mclk_i);
        issue_valid_i <= v;
        // reserved bits are randomised since the slice must ignore them
        issue_word_i <= {pri, d, s1, s2, 3'($urandom), mn};
        if (acc) begin
            exp_q.push_back({mn[5:4] == 2'b01, d, ref_op(mn, shadow[s1], shadow[s2])});
        end
        @(negedge mclk_i);
        check("issue_accept", 64'(accept), 64'(acc));
    endtask

    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc > 5000) begin
            bad_count++;
            report_and_stop();
        end
    end

    always @(posedge mclk_i) begin
        if (rst_n_i && we === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected_write", 64'h1, 64'h0);
            end else begin
                mon_e = exp_q.pop_front();
                check("wr_idx", 64'(wr_idx), 64'(mon_e[69:65]));
                check("wr_data", wr_data, mon_e[63:0]);
                check("flag_we", 64'(flag_we), 64'(mon_e[70]));
                if (mon_e[70]) begin
                    exp_flag = mon_e[64];
                end
                check("flag", 64'(flag), 64'(exp_flag));
            end
        end else if (rst_n_i && flag_we !== 1'b0) begin
            check("idle_flag_we", 64'(flag_we), 64'h0);
        end
    end

    initial begin
        int r;
        r = $urandom(78);
        for (int i = 0; i < 32; i++) begin
            shadow[i] = {$urandom, $urandom};
        end
        shadow[1] = 64'h0;
        shadow[2] = 64'hFFFF_FFFF_FFFF_FFFF;
        shadow[3] = shadow[3] & 64'hFEFE_FEFE_FEFE_FEFE;
        shadow[4] = shadow[3];
        // one lane above only, then every lane above
        shadow[5] = shadow[3] | 64'h0100_0000_0000_0000;
        shadow[6] = shadow[3] | 64'h0101_0101_0101_0101;
        shadow[7] = 64'h8080_8080_8080_8080;
        shadow[8] = 64'h7F7F_7F7F_7F7F_7F7F;
        for (int i = 0; i < 32; i++) begin
            @(posedge mclk_i);
            load_we <= 1'b1;
            load_idx <= 5'(i);
            load_data <= shadow[i];
            if (i == 8) begin
                rst_n_i <= 1'b1;
            end
        end
        @(posedge mclk_i);
        load_we <= 1'b0;
        @(negedge mclk_i);
        check("reset_flag", 64'(flag), 64'h0);
        check("reset_data", wr_data, 64'h0);
        for (int k = 0; k < 10; k++) begin
            for (int a = 1; a < 9; a++) begin
                for (int b = 1; b < 9; b++) begin
                    issue(1'b1, 6'h0A, 5'(24 + (a + b + k) % 8), 5'(a), 5'(b), ops[k]);
                end
            end
        end
        for (int n = 0; n < 400; n++) begin
            r = $urandom % 8;
            if (r == 0) begin
                issue(1'b0, 6'h0A, 5'h18, 5'h01, 5'h02, 8'h10);
            end else if (r == 1) begin
                issue(1'b1, 6'h0B, 5'h19, 5'($urandom % 24), 5'h03, 8'h12);
            end else if (r == 2) begin
                issue(1'b1, 6'h0A, 5'h1A, 5'h04, 5'h05, ($urandom % 2) ? 8'h18 : 8'h30);
            end else begin
                issue(1'b1, 6'h0A, 5'(24 + $urandom % 8), 5'($urandom % 24),
                      5'($urandom % 24), ops[$urandom % 10]);
            end
        end
        @(posedge mclk_i);
        issue_valid_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        check("pending_results", 64'(exp_q.size()), 64'h0);
        report_and_stop();
    end
endmodule
